// [design/dcsm_pkg.sv]
// Purpose: Shared constants and types of the DMA collision status monitor.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Status registers are 16 bits wide in the low half of each word.
package dcsm_pkg;

  localparam int unsigned DCSM_CHANNELS = 15;
  localparam int unsigned DCSM_REG_W = 16;
  localparam int unsigned DCSM_ADDR_W = 8;

  localparam logic [7:0] DCSM_OFS_LAST_ADDR = 8'h00;
  localparam logic [7:0] DCSM_OFS_WCOL = 8'h04;
  localparam logic [7:0] DCSM_OFS_RCOL = 8'h08;
  localparam logic [7:0] DCSM_OFS_FORCE = 8'h0c;
  localparam logic [7:0] DCSM_OFS_CLEAR = 8'h10;
  localparam logic [7:0] DCSM_OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] DCSM_OFS_IRQ_MASK = 8'h18;

  localparam logic [15:0] DCSM_RST_REG = 16'h0000;
  localparam logic [31:0] DCSM_RST_WORD = 32'h0000_0000;

  localparam int unsigned DCSM_IRQ_W = 3;
  localparam int unsigned DCSM_IRQ_WCOL = 0;
  localparam int unsigned DCSM_IRQ_RCOL = 1;
  localparam int unsigned DCSM_IRQ_ACCESS = 2;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [DCSM_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } dcsm_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dcsm_apb_rsp_t;

  typedef struct packed {
    logic valid;
    logic [DCSM_REG_W-1:0] addr;
  } dcsm_mem_access_t;

endpackage

// [design/dcsm_sticky_flags.sv]
// Purpose: Per-channel sticky collision flags with a request-collision detector.
// Assumes: Event strobes are synchronous one-cycle or level indications.
// Notes: A set in the same cycle as a clear wins, so no event is lost.
`timescale 1ns/1ps
`default_nettype none
module dcsm_sticky_flags
  import dcsm_pkg::*;
#(
  parameter int unsigned CHANNELS = DCSM_CHANNELS
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [CHANNELS-1:0] wcol_det_in,
  input wire logic [CHANNELS-1:0] force_req_in,
  input wire logic [CHANNELS-1:0] periph_req_in,
  input wire logic [CHANNELS-1:0] clear_in,
  output logic [CHANNELS-1:0] wcol_flag_out,
  output logic [CHANNELS-1:0] rcol_flag_out,
  output logic [CHANNELS-1:0] wcol_new_out,
  output logic [CHANNELS-1:0] rcol_new_out
);

  typedef struct packed {
    logic [CHANNELS-1:0] wcol;
    logic [CHANNELS-1:0] rcol;
  } dcsm_flag_state_t;

  dcsm_flag_state_t state_r;
  dcsm_flag_state_t state_nxt;
  logic [CHANNELS-1:0] rcol_det;

  ////////////////////////////////////////////////////////////////////////////
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      assign rcol_det[ch] = force_req_in[ch] & periph_req_in[ch];
    end
  endgenerate

  always_comb begin
    state_nxt = state_r;
    state_nxt.wcol = (state_r.wcol & ~clear_in) | wcol_det_in;
    state_nxt.rcol = (state_r.rcol & ~clear_in) | rcol_det;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign wcol_flag_out = state_r.wcol;
  assign rcol_flag_out = state_r.rcol;
  assign wcol_new_out = wcol_det_in;
  assign rcol_new_out = rcol_det;

endmodule // dcsm_sticky_flags
`default_nettype wire

// [design/dcsm_top.sv]
// Purpose: DMA collision status monitor with APB register access.
// Assumes: Single clock domain; DMA side inputs are synchronous to clk_in.
// Notes: Status registers are read-only; writes to them are accepted and ignored.
`timescale 1ns/1ps
`default_nettype none
module dcsm_top
  import dcsm_pkg::*;
#(
  parameter int unsigned CHANNELS = DCSM_CHANNELS
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [DCSM_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic mem_access_valid_in,
  input wire logic [DCSM_REG_W-1:0] mem_access_addr_in,
  input wire logic [CHANNELS-1:0] wcol_det_in,
  input wire logic [CHANNELS-1:0] periph_req_in,
  input wire logic [CHANNELS-1:0] force_done_in,
  input wire logic [CHANNELS-1:0] chan_enable_in,
  input wire logic [CHANNELS-1:0] chan_clear_in,
  output logic [CHANNELS-1:0] force_req_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [DCSM_REG_W-1:0] last_addr;
    logic [CHANNELS-1:0] force_req;
    logic [DCSM_IRQ_W-1:0] irq_stat;
    logic [DCSM_IRQ_W-1:0] irq_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } dcsm_state_t;

  dcsm_state_t state_r;
  dcsm_state_t state_nxt;
  dcsm_apb_req_t apb_req;
  dcsm_mem_access_t mem_acc;

  logic [CHANNELS-1:0] wcol_flag;
  logic [CHANNELS-1:0] rcol_flag;
  logic [CHANNELS-1:0] wcol_new;
  logic [CHANNELS-1:0] rcol_new;
  logic [CHANNELS-1:0] flag_clear;

  assign apb_req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
                     paddr: paddr_in, pwdata: pwdata_in};
  assign mem_acc = '{valid: mem_access_valid_in, addr: mem_access_addr_in};

  // A disabled channel drops its flags as well, which is the channel-level clear.
  assign flag_clear = chan_clear_in | ~chan_enable_in;

  ////////////////////////////////////////////////////////////////////////////
  // Collision flags.

  dcsm_sticky_flags #(
    .CHANNELS(CHANNELS)
  ) u_flags (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .wcol_det_in(wcol_det_in),
    .force_req_in(state_r.force_req),
    .periph_req_in(periph_req_in),
    .clear_in(flag_clear),
    .wcol_flag_out(wcol_flag),
    .rcol_flag_out(rcol_flag),
    .wcol_new_out(wcol_new),
    .rcol_new_out(rcol_new)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Places a channel vector in a 32-bit word; absent channel bits and bit 15 read zero.
  function automatic logic [31:0] chan_word(input logic [CHANNELS-1:0] v);
    logic [31:0] w;
    w = DCSM_RST_WORD;
    for (int i = 0; i < CHANNELS && i < 15; i++) begin
      w[i] = v[i];
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  logic access_phase;
  logic wr_acc;
  logic rd_acc;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [DCSM_IRQ_W-1:0] irq_events;
  logic [DCSM_IRQ_W-1:0] stat_after_read;

  // One wait state: pready is registered and rises one cycle into the access phase.
  assign access_phase = apb_req.psel & apb_req.penable & ~state_r.pready;
  assign wr_acc = access_phase & apb_req.pwrite;
  assign rd_acc = access_phase & ~apb_req.pwrite;

  always_comb begin
    rd_word = DCSM_RST_WORD;
    rd_hit = 1'b1;
    unique case (apb_req.paddr)
      DCSM_OFS_LAST_ADDR: begin
        rd_word = {16'h0000, state_r.last_addr};
      end
      DCSM_OFS_WCOL: begin
        rd_word = chan_word(wcol_flag);
      end
      DCSM_OFS_RCOL: begin
        rd_word = chan_word(rcol_flag);
      end
      DCSM_OFS_FORCE: begin
        rd_word = chan_word(state_r.force_req);
      end
      DCSM_OFS_CLEAR: begin
        rd_word = DCSM_RST_WORD;
      end
      DCSM_OFS_IRQ_STAT: begin
        rd_word = {29'h0000_0000, state_r.irq_stat};
      end
      DCSM_OFS_IRQ_MASK: begin
        rd_word = {29'h0000_0000, state_r.irq_mask};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    irq_events = '0;
    irq_events[DCSM_IRQ_WCOL] = |wcol_new;
    irq_events[DCSM_IRQ_RCOL] = |rcol_new;
    irq_events[DCSM_IRQ_ACCESS] = mem_acc.valid;
  end

  // Read-to-clear, but an event in the same cycle as the read survives.
  assign stat_after_read = (rd_acc && apb_req.paddr == DCSM_OFS_IRQ_STAT) ?
                           '0 : state_r.irq_stat;

  always_comb begin
    state_nxt = state_r;

    if (mem_acc.valid) begin
      state_nxt.last_addr = mem_acc.addr;
    end

    // Completion or disable clears; a write of 1 sets an enabled channel only, a write of 0 does nothing.
    state_nxt.force_req = state_r.force_req & ~force_done_in & chan_enable_in;
    if (wr_acc && apb_req.paddr == DCSM_OFS_FORCE) begin
      state_nxt.force_req = state_nxt.force_req |
                            (apb_req.pwdata[CHANNELS-1:0] & chan_enable_in);
    end

    if (wr_acc && apb_req.paddr == DCSM_OFS_IRQ_MASK) begin
      state_nxt.irq_mask = apb_req.pwdata[DCSM_IRQ_W-1:0];
    end

    state_nxt.irq_stat = stat_after_read | irq_events;
    state_nxt.irq = |(state_nxt.irq_stat & state_nxt.irq_mask);

    state_nxt.pready = access_phase;
    state_nxt.pslverr = access_phase & ~rd_hit;
    state_nxt.prdata = rd_acc ? rd_word : DCSM_RST_WORD;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign prdata_out = state_r.prdata;
  assign pready_out = state_r.pready;
  assign pslverr_out = state_r.pslverr;
  assign force_req_out = state_r.force_req;
  assign irq_out = state_r.irq;

endmodule // dcsm_top
`default_nettype wire

// [sim/dcsm_dma_model.sv]
// Purpose: DMA channel side model that completes forced transfers.
// Assumes: One clock; completion is a one-cycle pulse per channel.
// Notes: Holding stall_in high withholds completion, as a busy channel would.
`timescale 1ns/1ps
`default_nettype none
module dcsm_dma_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic stall_in,
  input wire logic [14:0] force_req_in,
  output logic [14:0] force_done_out
);
  logic [14:0] seen_r;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) seen_r <= '0;
    else seen_r <= force_req_in & ~seen_r & {15{!stall_in}};
  end
  assign force_done_out = seen_r;
endmodule // dcsm_dma_model
`default_nettype wire

// [sim/dcsm_monitor.sv]
// Purpose: Port level checks of the collision status monitor.
// Assumes: Status reads are compared with shadow copies kept here.
// Notes: Reads whose access cycle saw an event are skipped, as that order is open.
`timescale 1ns/1ps
`default_nettype none
module dcsm_monitor
  import dcsm_pkg::*;
#(
  parameter int unsigned CHANNELS = DCSM_CHANNELS
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic pwrite_in,
  input wire logic [DCSM_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic mem_access_valid_in,
  input wire logic [DCSM_REG_W-1:0] mem_access_addr_in,
  input wire logic [CHANNELS-1:0] wcol_det_in,
  input wire logic [CHANNELS-1:0] periph_req_in,
  input wire logic [CHANNELS-1:0] chan_enable_in,
  input wire logic [CHANNELS-1:0] chan_clear_in,
  input wire logic [CHANNELS-1:0] force_done_in,
  input wire logic [CHANNELS-1:0] force_req_out
);
  logic [15:0] last_r;
  logic [CHANNELS-1:0] wsh_r, rsh_r, kill;
  logic rd_ok;
  assign kill = chan_clear_in | ~chan_enable_in;
  assign rd_ok = pready_out && !pwrite_in;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_r <= '0;
      wsh_r <= '0;
      rsh_r <= '0;
    end else begin
      if (mem_access_valid_in) last_r <= mem_access_addr_in;
      wsh_r <= (wsh_r & ~kill) | wcol_det_in;
      rsh_r <= (rsh_r & ~kill) | (force_req_out & periph_req_in);
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  property p_last; rd_ok && paddr_in == DCSM_OFS_LAST_ADDR && !$past(mem_access_valid_in)
    |-> prdata_out == {16'h0000, last_r}; endproperty
  a_last: assert property (p_last) else $error("last address wrong");
  property p_last_hi; pready_out && paddr_in == DCSM_OFS_LAST_ADDR
    |-> prdata_out[31:16] == 16'h0000; endproperty
  a_last_hi: assert property (p_last_hi) else $error("last address high bits");
  property p_wcol; rd_ok && paddr_in == DCSM_OFS_WCOL && $past(wcol_det_in | kill) == '0
    |-> prdata_out == 32'(wsh_r); endproperty
  a_wcol: assert property (p_wcol) else $error("write flags wrong");
  property p_wcol_hi; pready_out && paddr_in == DCSM_OFS_WCOL
    |-> prdata_out[31:CHANNELS] == '0; endproperty
  a_wcol_hi: assert property (p_wcol_hi) else $error("write flags high bits");
  property p_rcol; rd_ok && paddr_in == DCSM_OFS_RCOL
    && $past((force_req_out & periph_req_in) | kill) == '0 |-> prdata_out == 32'(rsh_r); endproperty
  a_rcol: assert property (p_rcol) else $error("request flags wrong");
  property p_rcol_hi; pready_out && paddr_in == DCSM_OFS_RCOL
    |-> prdata_out[31:CHANNELS] == '0; endproperty
  a_rcol_hi: assert property (p_rcol_hi) else $error("request flags high bits");
  property p_force_set; (force_req_out & ~$past(force_req_out)) != '0
    |-> $past(pwrite_in && paddr_in == DCSM_OFS_FORCE); endproperty
  a_force_set: assert property (p_force_set) else $error("force bit set unasked");
  property p_force_hold; (~force_req_out & $past(force_req_out) & $past(chan_enable_in)
    & ~$past(force_done_in)) == '0; endproperty
  a_force_hold: assert property (p_force_hold) else $error("force bit lost");
endmodule // dcsm_monitor
bind dcsm_top dcsm_monitor #(.CHANNELS(CHANNELS)) dcsm_monitor_inst (.clk_in(clk_in),
  .rstn_in(rstn_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .mem_access_valid_in(mem_access_valid_in),
  .mem_access_addr_in(mem_access_addr_in), .wcol_det_in(wcol_det_in),
  .periph_req_in(periph_req_in), .chan_enable_in(chan_enable_in),
  .chan_clear_in(chan_clear_in), .force_done_in(force_done_in), .force_req_out(force_req_out));
`default_nettype wire

// [sim/dma_collision_status_monitor_tb.sv]
// Purpose: Self-checking bench of the collision status monitor.
// Assumes: APB master drives after rising edges and waits for pready.
// Notes: Flags are sticky, so table rows build on each other.
`timescale 1ns/1ps
`default_nettype none
module dma_collision_status_monitor_tb;
  import dcsm_pkg::*;
  logic clk_in, rstn_in, ps, pe, pw, mv, st, rdy, serr, irq, er;
  logic [7:0] pa;
  logic [31:0] wdt, prd, rd;
  logic [15:0] ma;
  logic [14:0] wd, pr, en, cl, fd, fq;
  int err_total = 0;
  int total_checks = 0;
  typedef struct packed {logic [15:0] a; logic [14:0] w; logic [31:0] e;} dcsm_row_t;
  dcsm_row_t rows [4] = '{'{16'h1234, 15'h0001, 32'h0001}, '{16'hffff, 15'h4000, 32'h4001},
    '{16'h0000, 15'h0000, 32'h4001}, '{16'ha5c3, 15'h7fff, 32'h7fff}};
  dcsm_top dcsm_top_inst (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(ps), .penable_in(pe),
    .pwrite_in(pw), .paddr_in(pa), .pwdata_in(wdt), .prdata_out(prd), .pready_out(rdy),
    .pslverr_out(serr), .mem_access_valid_in(mv), .mem_access_addr_in(ma), .wcol_det_in(wd),
    .periph_req_in(pr), .force_done_in(fd), .chan_enable_in(en), .chan_clear_in(cl),
    .force_req_out(fq), .irq_out(irq));
  dcsm_dma_model dcsm_dma_model_inst (.clk_in(clk_in), .rstn_in(rstn_in), .stall_in(st),
    .force_req_in(fq), .force_done_out(fd));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    ps <= 1;
    pe <= 0;
    pw <= w;
    pa <= a;
    wdt <= d;
    @(posedge clk_in);
    pe <= 1;
    // Pready is looked at mid-cycle, where it has settled, so the edge race is avoided.
    do begin
      @(negedge clk_in);
      n++;
    end while (rdy !== 1'b1 && n < 40);
    if (rdy !== 1'b1) err_total++;
    rd = prd;
    er = serr;
    @(posedge clk_in);
    ps <= 0;
    pe <= 0;
    // One idle edge keeps a following call from raising psel in the same step.
    @(posedge clk_in);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk("read", rd, e);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk_in = 0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
  initial begin
    {rstn_in, ps, pe, pw, mv, st, pa, wdt, ma, wd, pr, cl} = '0;
    en = '1;
    repeat (8) @(posedge clk_in);
    rstn_in <= 1;
    @(posedge clk_in);
    foreach (rows[i]) begin
      mv <= 1;
      ma <= rows[i].a;
      wd <= rows[i].w;
      @(posedge clk_in);
      mv <= 0;
      wd <= '0;
      rdc(DCSM_OFS_LAST_ADDR, {16'h0000, rows[i].a});
      rdc(DCSM_OFS_WCOL, rows[i].e);
    end
    $display("test table done");
    apb(DCSM_OFS_WCOL, 1'b1, '1);
    apb(DCSM_OFS_LAST_ADDR, 1'b1, '1);
    rdc(DCSM_OFS_WCOL, 32'h7fff);
    rdc(DCSM_OFS_LAST_ADDR, 32'ha5c3);
    apb(8'h1c, 1'b0, 32'h0);
    chk("slverr", er, 1);
    cl <= 15'h0001;
    en[14] <= 0;
    @(posedge clk_in);
    cl <= '0;
    en <= 15'h7fbf;
    pr[5] <= 1;
    st <= 1;
    apb(DCSM_OFS_FORCE, 1'b1, 32'h0060);
    rdc(DCSM_OFS_WCOL, 32'h3fbe);
    rdc(DCSM_OFS_FORCE, 32'h0020);
    apb(DCSM_OFS_FORCE, 1'b1, 32'h0);
    rdc(DCSM_OFS_FORCE, 32'h0020);
    rdc(DCSM_OFS_RCOL, 32'h0020);
    st <= 0;
    pr <= '0;
    en <= '1;
    repeat (2) @(posedge clk_in);
    rdc(DCSM_OFS_FORCE, 32'h0);
    $display("test force done");
    apb(DCSM_OFS_IRQ_STAT, 1'b0, 32'h0);
    apb(DCSM_OFS_IRQ_MASK, 1'b1, 32'h0);
    wd[2] <= 1;
    @(posedge clk_in);
    wd <= '0;
    repeat (2) @(posedge clk_in);
    chk("irq masked", irq, 0);
    apb(DCSM_OFS_IRQ_MASK, 1'b1, 32'h1);
    repeat (2) @(posedge clk_in);
    chk("irq raised", irq, 1);
    rdc(DCSM_OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk_in);
    chk("irq cleared", irq, 0);
    $display("test irq done");
    rstn_in <= 0;
    @(posedge clk_in);
    rstn_in <= 1;
    @(posedge clk_in);
    rdc(DCSM_OFS_LAST_ADDR, 32'h0);
    rdc(DCSM_OFS_WCOL, 32'h0);
    rdc(DCSM_OFS_RCOL, 32'h0);
    $display("test reset done");
    complete_run();
  end
endmodule // dma_collision_status_monitor_tb
`default_nettype wire
